// ===== rtl/cse_map.svh
// cse_map.svh : offsets, field positions, reset values and counts of the
// socket status-change block.
// assumes: included by bare name from the package and the design file.
//
// What this block does
// R1 - power cycle done sets event bit 3
// R2 - second card-detect change sets event bit 2
// R3 - first card-detect change sets event bit 1
// R4 - status-change pin change sets event bit 0
// R5 - software reads state to confirm power-up
// R6 - software reads both registers, clears verified flags
// R7 - enabled event flags drive the interrupt
// R8 - enable bits 31:4 read zero
// R9 - enable bit 3 gates power-cycle interrupt
// R10 - enable field 2:1 must be 11 for detect
// R11 - enable bit 0 cleared by removal, reset
// R12 - state register read-only, reserved bits zero
// R13 - state bit 29 shows socket 3.3V supply
// R14 - state bit 28 shows socket 5V supply
// R15 - state bit 11 shows card 3.3V capable
// R16 - state bit 10 shows card 5V capable
// R17 - never allow 5V for CardBus card
// R18 - state bits 2:1 mirror card-detect pins
// R19 - state bit 0 mirrors status-change pin
// R20 - state bit 3 shows interface powered up
// R21 - interrupt holds while enabled flag set
// R22 - event bits 31:4 read zero, ignore writes
`ifndef CSE_MAP_SVH
`define CSE_MAP_SVH

// ==========================================================
// register map
`define CSE_ADDR_W 8
`define CSE_OFF_EVENT 8'h00
`define CSE_OFF_ENABLE 8'h04
`define CSE_OFF_STATE 8'h08
`define CSE_OFF_INJECT 8'h0C
`define CSE_OFF_POWER 8'h10
`define CSE_OFF_CLOCK 8'h20

// ==========================================================
// field positions
`define CSE_EV_PWR 3
`define CSE_EV_CD2 2
`define CSE_EV_CD1 1
`define CSE_EV_STS 0
`define CSE_ST_SOCK3V 29
`define CSE_ST_SOCK5V 28
`define CSE_ST_CARD3V 11
`define CSE_ST_CARD5V 10
`define CSE_ST_PWRUP 3

// ==========================================================
// reset values and counts
`define CSE_EVENT_RST 4'h0
`define CSE_ENABLE_RST 4'h0
`define CSE_STATE_RST 32'h0000_0000
`define CSE_CD_ENABLE_ON 2'h3
`define CSE_SETTLE_CYC 2'h3
`define CSE_RESP_OKAY 2'h0
`define CSE_RESP_DECERR 2'h3

`endif

// ===== rtl/cse_pkg.sv
// cse_pkg.sv : types shared by the socket status-change block.
// assumes: cse_map.svh is on the include path.
package cse_pkg;
  `include "cse_map.svh"

  // register selected by a bus address
  typedef enum logic [2:0] {
    CSE_SEL_EVENT,
    CSE_SEL_ENABLE,
    CSE_SEL_STATE,
    CSE_SEL_SPARE,
    CSE_SEL_BAD
  } cse_sel_t;

  // kind of card seen in the socket
  typedef enum logic [1:0] {
    CSE_CARD_NONE,
    CSE_CARD_16BIT,
    CSE_CARD_CBUS
  } cse_card_t;

  // one flag per socket event
  typedef logic [3:0] cse_flags_t;
endpackage

// ===== rtl/cse_socket_events.sv
// cse_socket_events.sv : socket event flags, interrupt enables, live
// socket state and an AXI4-Lite slave for one card slot.
// assumes: one 50 MHz clock, synchronous active-high reset; power
// sequencing logic on the same clock gives the power inputs.
`timescale 1ns/10ps
`default_nettype none
`include "cse_map.svh"

module cse_socket_events (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // axi4-lite write address
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [`CSE_ADDR_W-1:0] AWADDR_I,
  // axi4-lite write data
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  // axi4-lite write response
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  // axi4-lite read address
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [`CSE_ADDR_W-1:0] ARADDR_I,
  // axi4-lite read data
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  // socket pins, asynchronous
  input wire logic [1:0] CARD_DETECT_PINS_N_I,
  input wire logic [1:0] VOLTAGE_SENSE_PINS_I,
  input wire logic CARD_STATUS_CHANGE_PIN_I,
  input wire logic SOCKET_3V_ABLE_I,
  input wire logic SOCKET_5V_ABLE_I,
  // power sequencer, same clock
  input wire logic POWER_CYCLE_DONE_I,
  input wire logic POWER_UP_OK_I,
  // outputs to interrupt routing and power control
  output logic STATUS_IRQ_O,
  output logic CARDBUS_CARD_O,
  output logic ALLOW_5V_O,
  output logic ALLOW_3V_O
);
  import cse_pkg::*;

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic cse_sel_t dec_addr(input logic [`CSE_ADDR_W-1:0] a);
    cse_sel_t s;
    s = CSE_SEL_BAD;
    case (a)
      `CSE_OFF_EVENT: s = CSE_SEL_EVENT;
      `CSE_OFF_ENABLE: s = CSE_SEL_ENABLE;
      `CSE_OFF_STATE: s = CSE_SEL_STATE;
      `CSE_OFF_INJECT, `CSE_OFF_POWER, `CSE_OFF_CLOCK: s = CSE_SEL_SPARE;
      default: s = CSE_SEL_BAD;
    endcase
    return s;
  endfunction

  // card kind and voltage from detect and sense pins: {kind, 3v, 5v}
  function automatic logic [3:0] dec_card(input logic [1:0] cd_n,
                                          input logic [1:0] vs);
    logic [3:0] r;
    r = {CSE_CARD_NONE, 2'b00};
    case (cd_n)
      2'b00: begin
        case (vs)
          2'b11: r = {CSE_CARD_16BIT, 2'b01};
          2'b01: r = {CSE_CARD_16BIT, 2'b10};
          default: r = {CSE_CARD_16BIT, 2'b11};
        endcase
      end
      2'b01, 2'b10: r = {CSE_CARD_CBUS, 2'b10};
      default: r = {CSE_CARD_NONE, 2'b00};
    endcase
    return r;
  endfunction

  // ==========================================================
  // pin synchronisers: {cap3, cap5, vs[1:0], cd_n[1:0], sts}
  logic [6:0] pin_raw;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  assign pin_raw = {SOCKET_3V_ABLE_I, SOCKET_5V_ABLE_I, VOLTAGE_SENSE_PINS_I,
                    CARD_DETECT_PINS_N_I, CARD_STATUS_CHANGE_PIN_I};

  // two flops per pin; only sync2_q is read further on
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // hold off edge detection until the synchronisers carry real pins
  logic [1:0] settle_q;
  logic settled;
  assign settled = (settle_q == `CSE_SETTLE_CYC);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      settle_q <= 2'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // ==========================================================
  // live socket state
  logic [2:0] pins_q;     // {cd2_n, cd1_n, sts} as shown to software
  logic card3v_q;         // card runs at 3.3V
  logic card5v_q;         // card runs at 5V
  logic cbus_q;           // card is a CardBus card
  logic sock3v_q;         // socket can give 3.3V
  logic sock5v_q;         // socket can give 5V
  logic pwrup_q;          // interface powered up
  logic [3:0] card_dec;
  logic [2:0] pin_chg;
  logic removal;
  logic [31:0] state_word;

  logic primed_q;         // pins_q holds real pin levels, not its reset zeros

  // pins_q first loads at the edge where settled is seen; only after that
  // is a difference a true pin change, else idle-high detects would look
  // like a removal right after reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      primed_q <= 1'b0;
    end else if (settled) begin
      primed_q <= 1'b1;
    end
  end

  assign card_dec = dec_card(sync2_q[2:1], sync2_q[4:3]);
  assign pin_chg = primed_q ? (sync2_q[2:0] ^ pins_q) : 3'b000;
  // card leaves: both detects were low, now one is high
  assign removal = primed_q && (pins_q[2:1] == 2'b00) && (sync2_q[2:1] != 2'b00);

  // state flops all clear at reset, then follow pins and power
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      pins_q <= 3'b000;
      card3v_q <= 1'b0;
      card5v_q <= 1'b0;
      cbus_q <= 1'b0;
      sock3v_q <= 1'b0;
      sock5v_q <= 1'b0;
      pwrup_q <= 1'b0;
    end else if (settled) begin
      pins_q <= sync2_q[2:0];                      // [R18] [R19]
      card3v_q <= card_dec[1];                     // [R15]
      card5v_q <= card_dec[0];                     // [R16]
      cbus_q <= (card_dec[3:2] == CSE_CARD_CBUS);
      sock3v_q <= sync2_q[6];                      // [R13]
      sock5v_q <= sync2_q[5];                      // [R14]
      pwrup_q <= POWER_UP_OK_I;                    // [R20]
    end
  end

  // read-only word, reserved bits tied low [R12]
  assign state_word = {2'b00, sock3v_q, sock5v_q, 16'h0000, card3v_q, card5v_q,
                       6'h00, pwrup_q, pins_q};

  // supply permits: no 5V for a CardBus card [R17]
  assign ALLOW_5V_O = card5v_q && sock5v_q && !cbus_q;
  assign ALLOW_3V_O = card3v_q && sock3v_q;
  assign CARDBUS_CARD_O = cbus_q;

  // ==========================================================
  // axi4-lite write channel
  logic aw_q;
  logic w_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [`CSE_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;
  cse_sel_t wr_sel;
  logic wr_lane0;

  assign AWREADY_O = !aw_q && !bvalid_q;
  assign WREADY_O = !w_q && !bvalid_q;
  assign do_wr = aw_q && w_q && !bvalid_q;
  assign wr_sel = dec_addr(awaddr_q);
  // every live field sits in byte lane 0
  assign wr_lane0 = do_wr && wstrb_q[0];
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;

  // address and data held until both are in, then one response
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CSE_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_q <= 1'b1;
        awaddr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_q <= 1'b1;
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == CSE_SEL_BAD) ? `CSE_RESP_DECERR : `CSE_RESP_OKAY;
      end else if (bvalid_q && BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // event flags and interrupt enables
  cse_flags_t ev_q;
  cse_flags_t en_q;
  cse_flags_t ev_set;
  cse_flags_t ev_clr;
  cse_flags_t irq_src;
  logic cd_irq_on;

  assign ev_set = {POWER_CYCLE_DONE_I, pin_chg};   // [R1] [R2] [R3] [R4]
  assign ev_clr = (wr_lane0 && wr_sel == CSE_SEL_EVENT) ? wdata_q[3:0] : 4'h0;
  // detect flags reach the interrupt only with both bits set [R10]
  assign cd_irq_on = (en_q[2:1] == `CSE_CD_ENABLE_ON);
  assign irq_src = ev_q & {en_q[`CSE_EV_PWR], cd_irq_on, cd_irq_on, en_q[`CSE_EV_STS]};
  assign STATUS_IRQ_O = |irq_src;                  // [R7] [R9] [R21]

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ev_q <= `CSE_EVENT_RST;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;           // [R1] [R2] [R3] [R4] [R22]
    end
  end

  // enables load from bus; card removal drops the status-change enable
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      en_q <= `CSE_ENABLE_RST;
    end else begin
      if (wr_lane0 && wr_sel == CSE_SEL_ENABLE) begin
        en_q <= wdata_q[3:0];                      // [R9] [R10]
      end
      if (removal) begin
        en_q[`CSE_EV_STS] <= 1'b0;                 // [R11]
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_hs;
  cse_sel_t rd_sel;
  logic [31:0] rd_word;

  assign ARREADY_O = !rvalid_q;
  assign ar_hs = ARVALID_I && ARREADY_O;
  assign rd_sel = dec_addr(ARADDR_I);
  // unused upper bits of event and enable read zero [R8] [R22]
  assign rd_word = (rd_sel == CSE_SEL_EVENT) ? {28'h000_0000, ev_q} :
                   (rd_sel == CSE_SEL_ENABLE) ? {28'h000_0000, en_q} :
                   (rd_sel == CSE_SEL_STATE) ? state_word : 32'h0000_0000;
  assign RVALID_O = rvalid_q;
  assign RDATA_O = rdata_q;
  assign RRESP_O = rresp_q;

  // data captured at the address handshake, held until taken
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CSE_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_sel == CSE_SEL_BAD) ? `CSE_RESP_DECERR : `CSE_RESP_OKAY;
    end else if (RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_power_flag_set: assert property ( // [R1]
    POWER_CYCLE_DONE_I |=> ev_q[`CSE_EV_PWR])
    else $error("power cycle event not flagged");
  a_detect2_flag_set: assert property ( // [R2]
    pin_chg[2] |=> ev_q[`CSE_EV_CD2] && (pins_q[2] == $past(sync2_q[2])))
    else $error("second detect change not flagged");
  a_detect1_flag_set: assert property ( // [R3]
    pin_chg[1] |=> ev_q[`CSE_EV_CD1] && (pins_q[1] == $past(sync2_q[1])))
    else $error("first detect change not flagged");
  a_status_flag_set: assert property ( // [R4]
    pin_chg[0] |=> ev_q[`CSE_EV_STS])
    else $error("status pin change not flagged");
  a_irq_needs_cause: assert property ( // [R7]
    STATUS_IRQ_O |-> (ev_q[3] && en_q[3]) || (ev_q[0] && en_q[0])
                     || ((ev_q[2] || ev_q[1]) && en_q[2:1] == 2'b11))
    else $error("interrupt without enabled flag");
  a_enable_rsvd_zero: assert property ( // [R8]
    ar_hs && rd_sel == CSE_SEL_ENABLE |=> rdata_q[31:4] == 28'h000_0000)
    else $error("enable reserved bits not zero");
  a_power_gate_off: assert property ( // [R9]
    ev_q == 4'h8 && !en_q[3] |-> !STATUS_IRQ_O)
    else $error("masked power event interrupts");
  a_detect_half_mask: assert property ( // [R10]
    ev_q[3] == 1'b0 && ev_q[0] == 1'b0 && en_q[2:1] != 2'b11 |-> !STATUS_IRQ_O)
    else $error("detect flags interrupt while masked");
  a_removal_drops_en: assert property ( // [R11]
    removal |=> !en_q[`CSE_EV_STS])
    else $error("status enable kept after removal");
  a_state_rsvd_zero: assert property ( // [R12]
    ar_hs && rd_sel == CSE_SEL_STATE |=> rdata_q[31:30] == 2'b00
                                         && rdata_q[27:12] == 16'h0000)
    else $error("state reserved bits not zero");
  a_cardbus_no_5v: assert property ( // [R17]
    cbus_q |-> !ALLOW_5V_O)
    else $error("5V allowed for CardBus card");
  // card removal drops the status enable by itself, so it may end the request
  a_irq_holds: assert property ( // [R21]
    STATUS_IRQ_O && !do_wr && !removal |=> STATUS_IRQ_O)
    else $error("interrupt dropped without software action");
  a_event_hi_zero: assert property ( // [R22]
    ar_hs && rd_sel == CSE_SEL_EVENT |=> rdata_q[31:4] == 28'h000_0000)
    else $error("event upper bits not zero");
  a_sock3v_follows: assert property ( // [R13]
    settled |=> sock3v_q == $past(sync2_q[6]))
    else $error("socket 3.3V bit not following its pin");
  a_sock5v_follows: assert property ( // [R14]
    settled |=> sock5v_q == $past(sync2_q[5]))
    else $error("socket 5V bit not following its pin");
  a_card3v_present: assert property ( // [R15]
    card3v_q |-> pins_q[2:1] != 2'b11)
    else $error("3.3V card reported with empty socket");
  a_card5v_16bit: assert property ( // [R16]
    card5v_q |-> pins_q[2:1] == 2'b00)
    else $error("5V card reported without a 16-bit card");
  a_pins_mirror: assert property ( // [R18] [R19]
    settled |=> pins_q == $past(sync2_q[2:0]))
    else $error("state pin bits not mirroring pins");
  a_pwrup_follows: assert property ( // [R20]
    settled |=> pwrup_q == $past(POWER_UP_OK_I))
    else $error("power-up bit not following sequencer");

endmodule
`default_nettype wire

// ===== tb/cse_socket_model.sv
// cse_socket_model.sv : card socket as seen at the block's pins.
// assumes: the bench picks card kind, sense levels and status level.
`timescale 1ns/10ps
`default_nettype none

module cse_socket_model (
  // card choice from the bench
  input wire cse_pkg::cse_card_t kind_i,
  input wire logic [1:0] sense_i,
  input wire logic sts_i,
  // socket pins toward the block
  output logic [1:0] det_n_o,
  output logic [1:0] sense_o,
  output logic sts_o
);
  import cse_pkg::*;
  // ==========================================
  // pins
  // detect pins are pulled up in an empty socket; cardbus grounds one
  assign det_n_o = (kind_i == CSE_CARD_16BIT) ? 2'h0 :
                   (kind_i == CSE_CARD_CBUS) ? 2'h1 : 2'h3;
  // sense pins float to their pull-ups with no card
  assign sense_o = (kind_i == CSE_CARD_NONE) ? 2'h3 : sense_i;
  // status pin is pulled down with no card
  assign sts_o = (kind_i == CSE_CARD_NONE) ? 1'b0 : sts_i;
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// testbench.sv : self-checking bench of the socket status-change block.
// assumes: cse_pkg compiled first, cse_map.svh on the include path.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import cse_pkg::*;
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic awr, wrd, bv, arr, rv, irq, cbus, a5, a3;
  logic [1:0] br, rr, det, vs;
  logic [1:0] vsel = 2'h0;
  logic sts, stsel = 1'b0, s3 = 1'b1, s5 = 1'b1, pdone = 1'b0, pok = 1'b0;
  cse_card_t kind = CSE_CARD_NONE;
  int mismatches = 0, checked = 0, cyc = 0;
  logic [31:0] rs = 32'h0000_0025; // xorshift state, seed 37

  cse_socket_events dut (.CLK_SYS_I(clk), .RST_I(rst),
    .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
    .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(4'hF),
    .BVALID_O(bv), .BREADY_I(bry), .BRESP_O(br),
    .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
    .RVALID_O(rv), .RREADY_I(rry), .RDATA_O(rd), .RRESP_O(rr),
    .CARD_DETECT_PINS_N_I(det), .VOLTAGE_SENSE_PINS_I(vs),
    .CARD_STATUS_CHANGE_PIN_I(sts), .SOCKET_3V_ABLE_I(s3), .SOCKET_5V_ABLE_I(s5),
    .POWER_CYCLE_DONE_I(pdone), .POWER_UP_OK_I(pok), .STATUS_IRQ_O(irq),
    .CARDBUS_CARD_O(cbus), .ALLOW_5V_O(a5), .ALLOW_3V_O(a3));

  cse_socket_model u_sock (.kind_i(kind), .sense_i(vsel), .sts_i(stsel),
    .det_n_o(det), .sense_o(vs), .sts_o(sts));

  // ==========================================
  // clock and hang guard
  always #10 clk = ~clk;
  // whole run needs about two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  // ==========================================
  // helpers
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // live state word from pin levels; reserved bits 9:4 are masked
  function logic [31:0] st_exp();
    logic c3, c5;
    c3 = (det != 2'h3) && !(det == 2'h0 && vs == 2'h3);
    c5 = (det == 2'h0) && (vs != 2'h1);
    return {2'h0, s3, s5, 16'h0000, c3, c5, 6'h00, pok, det, sts};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // settle, then sample between edges
  task idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // one write: address and data offered together, each dropped when taken
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awr === 1'b1) begin ta = 1'b1; awv <= 1'b0; end
      if (!tw && wrd === 1'b1) begin tw = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
  task wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", 32'(r), 32'h0000_0000);
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk("rresp", 32'(r), 32'h0000_0000);
    chk(n, d & m, e & m);
  endtask
  task irq_is(input logic e);
    idle(1);
    chk("irq", 32'(irq), 32'(e));
  endtask
  task complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin : main_seq
    logic [31:0] r, m;
    logic [1:0] rsp;
    m = 32'hFFFF_FC0F;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk("event", 8'h00, 32'h0000_0000, '1);
    rchk("enable", 8'h04, 32'h0000_0000, '1);
    idle(8);
    rchk("state", 8'h08, st_exp(), m);
    wok(8'h08, 32'hFFFF_FFFF);
    rchk("state_ro", 8'h08, st_exp(), m);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wok(8'h04, r);
      rchk("enable", 8'h04, {28'h000_0000, r[3:0]}, '1);
    end
    axw(8'h14, 32'h0000_000F, rsp);
    chk("bresp_unmapped", 32'(rsp), 32'h0000_0003);
    axr(8'h14, r, rsp);
    chk("rresp_unmapped", 32'(rsp), 32'h0000_0003);
    rchk("spare", 8'h0C, 32'h0000_0000, '1);
    wok(8'h00, 32'hFFFF_FFF0);
    rchk("event_hi", 8'h00, 32'h0000_0000, '1);
    // power cycle completes while its enable is off
    wok(8'h04, 32'h0000_0000);
    @(posedge clk);
    pok <= 1'b1;
    pdone <= 1'b1;
    @(posedge clk);
    pdone <= 1'b0;
    idle(2);
    rchk("event", 8'h00, 32'h0000_0008, '1);
    irq_is(1'b0);
    rchk("state", 8'h08, st_exp(), m);
    wok(8'h04, 32'h0000_0008);
    irq_is(1'b1);
    wok(8'h00, 32'h0000_0008);
    irq_is(1'b0);
    rchk("event", 8'h00, 32'h0000_0000, '1);
    // insertion with detect enables at 11, then 01
    wok(8'h04, 32'h0000_0006);
    @(posedge clk);
    kind <= CSE_CARD_16BIT;
    idle(8);
    rchk("event", 8'h00, 32'h0000_0006, '1);
    irq_is(1'b1);
    wok(8'h04, 32'h0000_0002);
    irq_is(1'b0);
    wok(8'h00, 32'h0000_0006);
    for (int v = 0; v < 4; v++) begin
      r = xs();
      @(posedge clk);
      vsel <= v[1:0];
      s3 <= r[0];
      s5 <= r[1];
      idle(8);
      rchk("state", 8'h08, st_exp(), m);
      chk("allow5", 32'(a5), 32'(st_exp() >> 10 & s5));
      chk("allow3", 32'(a3), 32'(st_exp() >> 11 & s3));
    end
    // status pin change
    wok(8'h04, 32'h0000_0001);
    @(posedge clk);
    stsel <= 1'b1;
    idle(8);
    rchk("event", 8'h00, 32'h0000_0001, '1);
    irq_is(1'b1);
    rchk("state", 8'h08, st_exp(), m);
    // removal clears the status enable and flags both detects
    @(posedge clk);
    kind <= CSE_CARD_NONE;
    idle(8);
    rchk("enable", 8'h04, 32'h0000_0000, '1);
    rchk("event", 8'h00, 32'h0000_0007, '1);
    // cardbus card never gets the 5V supply
    @(posedge clk);
    s5 <= 1'b1;
    kind <= CSE_CARD_CBUS;
    idle(8);
    chk("cardbus", 32'(cbus), 32'h0000_0001);
    chk("allow5", 32'(a5), 32'h0000_0000);
    complete_run();
  end
endmodule

`default_nettype wire
